// file: logic/dma_map.vh
// Register offsets, field positions, reset values and codes of the DMA block
`ifndef DMA_MAP_VH
`define DMA_MAP_VH
// Per-channel register words, channel n at byte n*16
`define CH_CTRL 2'h0
`define CH_SRC 2'h1
`define CH_DST 2'h2
`define CH_CNT 2'h3
`define CHAN_REGS_END 8'h60
// Global registers
`define REG_PRIO_EN 8'h60
`define REG_INDEX 8'h64
`define REG_BANK_SW 8'h68
`define REG_STATUS 8'h6C
// Channel control fields
`define F_SYNC 3:0
`define F_SRC_MODE 5:4
`define F_DST_MODE 7:6
`define F_SRC_IO 8
`define F_DST_IO 9
`define F_DWORD 10
`define F_HALF_EN 11
`define F_FULL_EN 12
// Priority and enable fields
`define F_ENABLE 5:0
`define F_PRIO 13:8
`define F_ROUTE 17:16
// Bank switch control: peer request bit
`define F_PEER_REQ 8
// Sync event codes
`define SYNC_NONE 4'h0
`define SYNC_FIFO_IN 4'h7
`define SYNC_FIFO_OUT 4'h8
// Interrupt routing codes
`define ROUTE_RESET 2'h0
`define ROUTE_HI 2'h1
`define ROUTE_ALL 2'h2
// Address step modes
`define STEP_HOLD 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
// Peer FIFO depth in words
`define FIFO_WORDS 8
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: logic/addr_step.v
// Address update unit for one side of the active channel
`timescale 1ns/10ps
`include "dma_map.vh"
module addr_step
(
   // Current address and step mode
   input wire [15:0] addr,
   input wire [1:0] mode,
   input wire [15:0] index,
   // Address for the next word
   output reg [15:0] next_addr
);

// ****************************************
// Step selection
// ****************************************
// Plain wrap-around arithmetic, no bound checks
always @*
begin
   case (mode)
      `STEP_HOLD: next_addr = addr;
      `STEP_INC: next_addr = addr + 16'h0001;
      `STEP_DEC: next_addr = addr - 16'h0001;
      default: next_addr = addr + index;
   endcase
end

endmodule

// file: logic/peer_fifo.v
// One-way peer FIFO with registered read data
`timescale 1ns/10ps
module peer_fifo
#(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Fill side
   input wire push,
   input wire [WIDTH-1:0] push_data,
   output wire full,
   // Drain side
   input wire pop,
   output reg [WIDTH-1:0] pop_data,
   output wire empty,
   // Occupancy
   output reg [AW:0] level
);

// ****************************************
// Storage and pointers
// ****************************************
reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word store, DEPTH a power of two
reg [AW-1:0] wptr; // Next slot to fill
reg [AW-1:0] rptr; // Next slot to drain
localparam [AW:0] FULL_LEVEL = DEPTH;

// Refused accesses leave everything untouched
wire do_push = push & ~full; // RL20
wire do_pop = pop & ~empty; // RL20

assign full = (level == FULL_LEVEL);
assign empty = (level == {(AW+1){1'b0}});

// Storage has no reset, saving area
always @(posedge aclk)
begin
   if (do_push)
      mem[wptr] <= push_data;
end

// Pointers, level and output word
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      pop_data <= {WIDTH{1'b0}};
   end
   else
   begin
      if (do_push)
         wptr <= wptr + 1'b1;
      if (do_pop)
      begin
         rptr <= rptr + 1'b1;
         pop_data <= mem[rptr];
      end
      level <= level + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
   end
end

endmodule

// file: logic/dsp_dma.v
// Six-channel DMA engine with peer FIFOs, routing and AXI4-Lite registers
`timescale 1ns/10ps
`include "dma_map.vh"

//Contract
// (RL1) Six channels, each a full transfer context
// (RL2) Engine wins memory over the core
// (RL3) Per-channel priority picks among pending channels
// (RL4) Source/destination step: hold, up, down, index
// (RL5) Sync codes 0-6: free, serial events
// (RL6) Codes 7/8 FIFO events; 9-15 reserved
// (RL7) Half-block or full-block channel interrupt
// (RL8) Four cycles per on-chip transfer; engine takes five per word, idle included, four for a double-word's second word
// (RL9) Double-word moves two consecutive words
// (RL10) I/O space means peer FIFO, address ignored
// (RL11) Channels 0/1 share lines 6 and 7
// (RL12) Channels 2/3 share lines 10 and 11
// (RL13) Routing select resets to serial ports
// (RL14) Route 01 upper pair, 10 all four
// (RL15) Auxiliary channel serves host port accesses
// (RL16) Two one-way eight-word peer FIFOs
// (RL17) FIFOs reached only through engine I/O
// (RL18) Peer request bit raises peer interrupt
// (RL19) Request must clear before next interrupt
// (RL20) Full FIFO drops writes, empty ignores reads
// (RL21) One element per event; free runs on
module dsp_dma
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Internal memory port
   output reg mem_req,
   output reg mem_we,
   output reg [15:0] mem_addr,
   output reg [15:0] mem_wdata,
   input wire [15:0] mem_rdata,
   // Core access to the same memory
   input wire cpu_mem_req,
   output wire cpu_mem_grant,
   // Serial port events, index = port number
   input wire [2:0] serial_rx_event,
   input wire [2:0] serial_tx_event,
   // Serial port interrupts sharing lines
   input wire port2_rx_irq,
   input wire port2_tx_irq,
   input wire port1_rx_irq,
   input wire port1_tx_irq,
   // Interrupt lines: [0]=6 [1]=7 [2]=10 [3]=11
   output reg [3:0] shared_irq,
   output reg chan4_done_irq,
   output reg chan5_done_irq,
   // Host port auxiliary channel
   input wire host_req,
   input wire host_we,
   input wire [15:0] host_addr,
   input wire [15:0] host_wdata,
   output reg host_ack,
   output reg [15:0] host_rdata,
   // Peer subsystem: inbound FIFO fill side
   input wire peer_in_push,
   input wire [15:0] peer_in_data,
   output wire peer_in_ready,
   // Peer subsystem: outbound FIFO drain side
   input wire peer_out_pop,
   output wire [15:0] peer_out_data,
   output wire peer_out_valid,
   // Interrupt to the peer subsystem
   output reg peer_irq
);

// ****************************************
// Constants and state codes
// ****************************************
localparam NCH = 6; // Channel count
localparam [6:0] ST_IDLE = 7'b0000001; // Waiting for work
localparam [6:0] ST_RD = 7'b0000010; // Source read on the port
localparam [6:0] ST_WT = 7'b0000100; // Read data back, issue write
localparam [6:0] ST_WR = 7'b0001000; // Destination write on the port
localparam [6:0] ST_UPD = 7'b0010000; // Count and interrupts
localparam [6:0] ST_AX = 7'b0100000; // Host access on the port
localparam [6:0] ST_AK = 7'b1000000; // Host answer

// ****************************************
// Channel context and global registers
// ****************************************
reg [12:0] ch_ctrl [0:NCH-1]; // RL1
reg [15:0] src_addr [0:NCH-1]; // Source pointer
reg [15:0] dst_addr [0:NCH-1]; // Destination pointer
reg [15:0] cnt [0:NCH-1]; // Elements still to move
reg [15:0] cnt_total [0:NCH-1]; // Block size, for the half mark
reg [5:0] enable; // Channel enables, cleared at block end
reg [5:0] prio; // One = high priority
reg [1:0] route; // Shared interrupt routing
reg [15:0] index; // Step for index mode
reg peer_req; // Peer interrupt request bit
reg [5:0] pend; // Latched serial events
reg [5:0] chan_irq; // Per-channel interrupt pulses
integer i;
integer j;
integer k;

// ****************************************
// Engine state
// ****************************************
reg [6:0] state;
reg [2:0] cur; // Channel being served
reg second; // Second word of a double-word element
reg in_pop; // Inbound FIFO read strobe
reg out_push; // Outbound FIFO write strobe

// ****************************************
// Peer FIFOs
// ****************************************
wire [15:0] in_data;
wire in_empty;
wire in_full;
wire [3:0] in_level;
wire out_full;
wire out_empty;
wire [3:0] out_level;

// Inbound: peer fills, engine drains via I/O space
peer_fifo #(.WIDTH(16), .DEPTH(`FIFO_WORDS), .AW(3)) u_in_fifo // RL16
(
   .aclk(aclk),
   .aresetn(aresetn),
   .push(peer_in_push),
   .push_data(peer_in_data),
   .full(in_full),
   .pop(in_pop), // RL17
   .pop_data(in_data),
   .empty(in_empty),
   .level(in_level)
);

// Outbound: engine fills via I/O space, peer drains
peer_fifo #(.WIDTH(16), .DEPTH(`FIFO_WORDS), .AW(3)) u_out_fifo // RL16
(
   .aclk(aclk),
   .aresetn(aresetn),
   .push(out_push), // RL17
   .push_data(mem_wdata),
   .full(out_full),
   .pop(peer_out_pop),
   .pop_data(peer_out_data),
   .empty(out_empty),
   .level(out_level)
);

assign peer_in_ready = ~in_full;
assign peer_out_valid = ~out_empty;

// Engine holds the port; the core waits
assign cpu_mem_grant = cpu_mem_req & ~mem_req; // RL2

// ****************************************
// Channel selection
// ****************************************
wire [12:0] cc = ch_ctrl[cur]; // Active channel control
// Serial event codes 1 to 6; other codes never latch
wire [15:0] ev_ser = {9'h000, serial_tx_event[1], serial_rx_event[1],
   serial_tx_event[2], serial_rx_event[2], serial_tx_event[0],
   serial_rx_event[0], 1'b0}; // RL5
reg [5:0] ready;
reg [2:0] pick;
reg found;

// Ready test, then lowest index among high, else among low
always @*
begin
   ready = 6'h00;
   pick = 3'h0;
   found = 1'b0;
   for (k = 0; k < NCH; k = k + 1)
   begin
      // Free runs on, FIFO codes follow levels, serial codes latch
      ready[k] = enable[k] & (|cnt[k]) &
         ((ch_ctrl[k][`F_SYNC] == `SYNC_NONE) |
         ((ch_ctrl[k][`F_SYNC] == `SYNC_FIFO_IN) & ~in_empty) |
         ((ch_ctrl[k][`F_SYNC] == `SYNC_FIFO_OUT) & ~out_full) |
         pend[k]); // RL21 RL6
   end
   for (k = NCH - 1; k >= 0; k = k - 1)
   begin
      if (ready[k] & ~prio[k])
      begin
         pick = k[2:0];
         found = 1'b1;
      end
   end
   // High priority pass overrides the low one
   for (k = NCH - 1; k >= 0; k = k - 1)
   begin
      if (ready[k] & prio[k])
      begin
         pick = k[2:0]; // RL3
         found = 1'b1;
      end
   end
end

// Host is served first; channel start consumes one event
wire host_go = host_req & ~host_ack; // RL15
wire take = (state == ST_IDLE) & ~host_go & found;
wire redo = (state == ST_UPD) & cc[`F_DWORD] & ~second; // RL9
wire [2:0] rd_ch = (state == ST_IDLE) ? pick : cur;

// ****************************************
// Address and count updates
// ****************************************
wire [15:0] src_next;
wire [15:0] dst_next;
wire src_upd = (state == ST_WT); // After each read
wire dst_upd = (state == ST_WR); // After each write
wire cnt_upd = (state == ST_UPD) & ~redo;
wire [15:0] cnt_now = cnt[cur];
wire [15:0] cnt_next = cnt_now - 16'h0001;
wire [15:0] half_mark = {1'b0, cnt_total[cur][15:1]};
// FIFO word replaces memory data on I/O reads
wire [15:0] rd_word = cc[`F_SRC_IO] ? in_data : mem_rdata; // RL10

addr_step u_src_step // RL4
(
   .addr(src_addr[cur]),
   .mode(cc[`F_SRC_MODE]),
   .index(index),
   .next_addr(src_next)
);

addr_step u_dst_step // RL4
(
   .addr(dst_addr[cur]),
   .mode(cc[`F_DST_MODE]),
   .index(index),
   .next_addr(dst_next)
);

// ****************************************
// Engine sequence
// ****************************************
// Idle, read, data, write, update: five cycles per word; a double-word's second word takes four
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      state <= ST_IDLE;
      cur <= 3'h0;
      second <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      in_pop <= 1'b0;
      out_push <= 1'b0;
      host_ack <= 1'b0;
      host_rdata <= 16'h0000;
   end
   else
   begin
      // Strobes last one cycle
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      in_pop <= 1'b0;
      out_push <= 1'b0;
      host_ack <= 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (host_go)
            begin
               state <= ST_AX; // RL15
               mem_req <= 1'b1;
               mem_we <= host_we;
               mem_addr <= host_addr;
               mem_wdata <= host_wdata;
            end
            else if (found)
            begin
               cur <= pick;
               second <= 1'b0;
               state <= ST_RD; // RL8
               mem_req <= ~ch_ctrl[rd_ch][`F_SRC_IO]; // RL10
               in_pop <= ch_ctrl[rd_ch][`F_SRC_IO];
               mem_addr <= src_addr[rd_ch];
            end
         end
         ST_RD:
            state <= ST_WT;
         ST_WT:
         begin
            // Issue the write with the word just read
            state <= ST_WR;
            mem_req <= ~cc[`F_DST_IO]; // RL10
            mem_we <= ~cc[`F_DST_IO];
            out_push <= cc[`F_DST_IO];
            mem_addr <= dst_addr[cur];
            mem_wdata <= rd_word;
         end
         ST_WR:
            state <= ST_UPD;
         ST_UPD:
         begin
            if (redo)
            begin
               // Second word follows without a new event
               second <= 1'b1; // RL9
               state <= ST_RD;
               mem_req <= ~ch_ctrl[rd_ch][`F_SRC_IO];
               in_pop <= ch_ctrl[rd_ch][`F_SRC_IO];
               mem_addr <= src_addr[rd_ch];
            end
            else
               state <= ST_IDLE;
         end
         ST_AX:
            state <= ST_AK;
         ST_AK:
         begin
            // Ack also blocks a repeat while host drops req
            host_rdata <= mem_rdata;
            host_ack <= 1'b1;
            state <= ST_IDLE;
         end
         default:
            state <= ST_IDLE;
      endcase
   end
end

// ****************************************
// Serial event latches
// ****************************************
// A new event in the take cycle wins over the clear
always @(posedge aclk)
begin
   if (!aresetn)
      pend <= 6'h00;
   else
      for (j = 0; j < NCH; j = j + 1)
         pend[j] <= (pend[j] & ~(take & (pick == j[2:0]))) |
            ev_ser[ch_ctrl[j][`F_SYNC]]; // RL21
end

// ****************************************
// AXI4-Lite write and read channels
// ****************************************
reg aw_held;
reg w_held;
reg [7:0] wr_addr;
reg [31:0] wr_data;
reg [3:0] wr_strb;
wire wr_go = aw_held & w_held & ~s_axi_bvalid;
wire wr_ok = (wr_addr <= `REG_STATUS);

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

// Register contents as software sees them
function [31:0] reg_val;
   input [7:0] a;
   begin
      reg_val = 32'h00000000;
      if (a < `CHAN_REGS_END)
         case (a[3:2])
            `CH_CTRL: reg_val = {19'h00000, ch_ctrl[a[6:4]]};
            `CH_SRC: reg_val = {16'h0000, src_addr[a[6:4]]};
            `CH_DST: reg_val = {16'h0000, dst_addr[a[6:4]]};
            default: reg_val = {16'h0000, cnt[a[6:4]]};
         endcase
      else
         case (a)
            `REG_PRIO_EN:
               reg_val = {14'h0000, route, 2'h0, prio, 2'h0, enable};
            `REG_INDEX: reg_val = {16'h0000, index};
            `REG_BANK_SW: reg_val = {23'h000000, peer_req, 8'h00};
            `REG_STATUS:
               reg_val = {16'h0000, out_level, in_level, 2'h0, out_full,
                  in_empty, cur, (state != ST_IDLE)};
            default: reg_val = 32'h00000000;
         endcase
   end
endfunction

// Byte lanes not strobed keep their old value
function [31:0] merge;
   input [31:0] o;
   input [31:0] n;
   input [3:0] s;
   integer b;
   begin
      merge = o;
      for (b = 0; b < 4; b = b + 1)
         if (s[b])
            merge[8*b +: 8] = n[8*b +: 8];
   end
endfunction

wire [31:0] wv = merge(reg_val(wr_addr), wr_data, wr_strb);

// Address and data taken in either order
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
   end
   else
   begin
      if (s_axi_awvalid & s_axi_awready)
      begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
         w_held <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
         s_axi_bvalid <= 1'b0;
      // Unmapped reads answer zero with an error
      if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= (s_axi_araddr <= `REG_STATUS) ?
            reg_val(s_axi_araddr) : 32'h00000000;
         s_axi_rresp <= (s_axi_araddr <= `REG_STATUS) ?
            `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
end

// ****************************************
// Register file and context updates
// ****************************************
// Engine updates follow software writes, so they win
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      for (i = 0; i < NCH; i = i + 1)
      begin
         ch_ctrl[i] <= 13'h0000;
         src_addr[i] <= 16'h0000;
         dst_addr[i] <= 16'h0000;
         cnt[i] <= 16'h0000;
         cnt_total[i] <= 16'h0000;
      end
      enable <= 6'h00;
      prio <= 6'h00;
      route <= `ROUTE_RESET; // RL13
      index <= 16'h0000;
      peer_req <= 1'b0;
      peer_irq <= 1'b0;
   end
   else
   begin
      peer_irq <= 1'b0;
      if (wr_go & wr_ok)
      begin
         if (wr_addr < `CHAN_REGS_END)
            case (wr_addr[3:2])
               `CH_CTRL: ch_ctrl[wr_addr[6:4]] <= wv[12:0];
               `CH_SRC: src_addr[wr_addr[6:4]] <= wv[15:0];
               `CH_DST: dst_addr[wr_addr[6:4]] <= wv[15:0];
               default:
               begin
                  cnt[wr_addr[6:4]] <= wv[15:0];
                  cnt_total[wr_addr[6:4]] <= wv[15:0];
               end
            endcase
         else
            case (wr_addr)
               `REG_PRIO_EN:
               begin
                  enable <= wv[`F_ENABLE];
                  prio <= wv[`F_PRIO];
                  route <= wv[`F_ROUTE];
               end
               `REG_INDEX: index <= wv[15:0];
               `REG_BANK_SW:
               begin
                  // Only a 0 to 1 change reaches the peer
                  peer_req <= wv[`F_PEER_REQ]; // RL18
                  peer_irq <= wv[`F_PEER_REQ] & ~peer_req; // RL19
               end
               default: peer_irq <= 1'b0;
            endcase
      end
      if (src_upd)
         src_addr[cur] <= src_next; // RL4
      if (dst_upd)
         dst_addr[cur] <= dst_next; // RL4
      if (cnt_upd)
      begin
         cnt[cur] <= cnt_next;
         if (cnt_next == 16'h0000)
            enable[cur] <= 1'b0;
      end
   end
end

// ****************************************
// Channel interrupts and routing
// ****************************************
// Pulses from the block end or half mark; routed a cycle later
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      chan_irq <= 6'h00;
      shared_irq <= 4'h0;
      chan4_done_irq <= 1'b0;
      chan5_done_irq <= 1'b0;
   end
   else
   begin
      chan_irq <= 6'h00;
      if (cnt_upd & ((cc[`F_HALF_EN] & (cnt_next == half_mark)) |
         (cc[`F_FULL_EN] & (cnt_next == 16'h0000))))
         chan_irq[cur] <= 1'b1; // RL7
      // Reserved route code behaves as the reset code
      shared_irq[0] <= (route == `ROUTE_ALL) ?
         chan_irq[0] : port2_rx_irq; // RL11 RL14
      shared_irq[1] <= (route == `ROUTE_ALL) ?
         chan_irq[1] : port2_tx_irq; // RL11 RL14
      shared_irq[2] <= ((route == `ROUTE_ALL) | (route == `ROUTE_HI)) ?
         chan_irq[2] : port1_rx_irq; // RL12 RL14
      shared_irq[3] <= ((route == `ROUTE_ALL) | (route == `ROUTE_HI)) ?
         chan_irq[3] : port1_tx_irq; // RL12 RL14
      chan4_done_irq <= chan_irq[4];
      chan5_done_irq <= chan_irq[5];
   end
end

endmodule

// file: dv/dma_checker.sv
// Port assertions for the six-channel DMA engine
`timescale 1ns/10ps
module dma_checker
(
   // Clock, reset, memory strobes and arbitration, peer interrupt
   input logic aclk, aresetn, cpu_mem_req, cpu_mem_grant,
   input logic mem_req, mem_we, peer_irq,
   // Outbound peer FIFO drain side
   input logic peer_out_pop, peer_out_valid,
   input logic [15:0] peer_out_data,
   // Register bus handshakes
   input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input logic s_axi_wready, s_axi_bvalid, s_axi_bready,
   input logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_engine_wins: assert property
      (cpu_mem_grant == (cpu_mem_req && !mem_req))
      else $error("core grant while engine holds memory");
   a_strobe_gap: assert property (mem_req |=> !mem_req)
      else $error("memory strobe held two cycles");
   a_peer_pulse: assert property (peer_irq |=> !peer_irq)
      else $error("peer interrupt longer than one cycle");
   a_peer_cause: assert property (peer_irq |-> $rose(s_axi_bvalid))
      else $error("peer interrupt without a register write");
   a_empty_pop: assert property
      (!peer_out_valid && peer_out_pop |=> $stable(peer_out_data))
      else $error("pop of empty FIFO changed data");
   a_read_answer: assert property
      (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   a_write_answer: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   // Main scenarios reached
   c_peer: cover property (peer_irq);
   c_write: cover property (mem_req && mem_we);
   c_fifo: cover property (peer_out_valid && peer_out_pop);
endmodule
bind dsp_dma dma_checker i_dma_checker (.*);

// file: dv/mem_model.sv
// Synchronous word memory at the engine's memory port
`timescale 1ns/10ps
module mem_model
(
   // Clock and engine strobes
   input logic aclk, mem_req, mem_we,
   input logic [15:0] mem_addr, mem_wdata,
   // Read data, valid the cycle after the strobe
   output logic [15:0] mem_rdata
);
   logic [15:0] ram [0:255]; // Small window of the word space
   initial mem_rdata = 16'h0;
   // Off a read the bus flips so no stale word looks valid
   always @(posedge aclk)
   begin
      if (mem_req && !mem_we)
         mem_rdata <= ram[mem_addr[7:0]];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_req && mem_we)
         ram[mem_addr[7:0]] <= mem_wdata;
   end
endmodule

// file: dv/test_dsp_dma.sv
// Register-level regression of the DMA engine
`timescale 1ns/10ps
module test_dsp_dma;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, shared_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, host_addr, host_wdata;
   logic [15:0] host_rdata, peer_in_data, peer_out_data;
   logic [2:0] serial_rx_event, serial_tx_event;
   logic cpu_mem_req, cpu_mem_grant, port2_rx_irq, port2_tx_irq;
   logic port1_rx_irq, port1_tx_irq, chan4_done_irq, chan5_done_irq;
   logic host_req, host_we, host_ack, peer_in_push, peer_in_ready;
   logic peer_out_pop, peer_out_valid, peer_irq;
   int n_fail = 0, n_compared = 0, cyc = 0, n_irq = 0;
   // Expected lines per route value, port 2 rx and port 1 rx raised
   logic [3:0] n_fail_tbl [0:3] = '{4'h5, 4'h1, 4'h0, 4'h5};
   dsp_dma i_dsp_dma (.*);
   mem_model i_mem_model (.*);
   initial
   begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   // Hang guard and peer interrupt tally
   always @(posedge aclk)
   begin
      cyc++;
      if (peer_irq === 1'b1)
         n_irq++;
      if (cyc == 20000)
      begin
         n_fail++;
         give_verdict;
      end
   end
   task give_verdict;
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input [31:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Write: both channels offered at once, each dropped when taken
   task wr(input [7:0] a, input [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
   endtask
   task rd(input [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 0;
   endtask
   task run_to_idle(input [31:0] en); // Waits for enables to clear
      do rd(8'h60); while (d[5:0] & en[5:0]);
      repeat (8) @(posedge aclk);
   endtask
   initial
   begin
      aresetn = 0; {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, cpu_mem_req, host_req} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, host_we} = 0;
      s_axi_wstrb = 4'hF; {serial_rx_event, serial_tx_event} = 0;
      {port2_rx_irq, port2_tx_irq, port1_rx_irq, port1_tx_irq} = 0;
      {host_addr, host_wdata, peer_in_push, peer_in_data} = 0;
      peer_out_pop = 0;
      for (int i = 0; i < 256; i++)
         i_mem_model.ram[i] = 16'hA500 + i[15:0];
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd(8'h60); chk("route reset", d, 32'h0);
      rd(8'h70); chk("unmapped resp", s_axi_rresp, 32'h2);
      port2_rx_irq <= 1; port1_rx_irq <= 1;
      foreach (n_fail_tbl[k])
      begin
         wr(8'h60, {14'h0, k[1:0], 16'h0});
         repeat (4) @(posedge aclk);
         chk("shared lines", shared_irq, n_fail_tbl[k]);
      end
      wr(8'h60, 32'h0);
      cpu_mem_req <= 1; // Core contends for memory throughout
      wr(8'h00, 32'h1050); wr(8'h04, 32'h10); wr(8'h08, 32'h20);
      wr(8'h0C, 32'h3); wr(8'h60, 32'h1);
      run_to_idle(32'h1);
      for (int i = 0; i < 4; i++)
         chk("block copy", i_mem_model.ram[32 + i],
            (i < 3) ? 16'hA510 + i : 16'hA523);
      // Host reads back a copied word through the auxiliary path
      host_req <= 1; host_addr <= 16'h0020;
      do @(posedge aclk); while (host_ack !== 1'b1);
      host_req <= 0;
      chk("host read", host_rdata, 16'hA510);
      wr(8'h10, 32'h0041); wr(8'h14, 32'h30); wr(8'h18, 32'h40);
      wr(8'h1C, 32'h2); wr(8'h60, 32'h2);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge aclk) serial_rx_event <= 3'h1;
         @(posedge aclk) serial_rx_event <= 3'h0;
         repeat (20) @(posedge aclk);
         chk("paced copy", i_mem_model.ram[8'h41],
            i ? 16'hA530 : 16'hA541);
      end
      wr(8'h20, 32'h0218); wr(8'h24, 32'h50); wr(8'h2C, 32'h2);
      wr(8'h60, 32'h4);
      run_to_idle(32'h4);
      // Third pop finds the FIFO empty and must keep the last word
      for (int i = 0; i < 3; i++)
      begin
         @(posedge aclk) peer_out_pop <= 1;
         @(posedge aclk) peer_out_pop <= 0;
         @(posedge aclk);
         chk("fifo word", peer_out_data, 16'hA550 + (i > 0));
      end
      wr(8'h68, 32'h100); wr(8'h68, 32'h100);
      wr(8'h68, 32'h0); wr(8'h68, 32'h100);
      @(posedge aclk);
      chk("peer irqs", n_irq, 32'h2);
      give_verdict;
   end
endmodule
